/* aus_streamer.sv */
// Converter-result to UART streamer: chained transfer engine,
// transmit and receive byte DMA with 512-byte rings, UART, comparator.
// Assumes conversion_done_request and result come from the same clock;
// the UART receive pin and clear-to-send pin are asynchronous.
`default_nettype none

module aus_streamer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire aus_pkg::aus_bus_t bus,
  output logic [31:0] reg_rdata,
  input wire logic conversion_done_request,
  input wire logic [31:0] conv_result,
  input wire logic uart_rx_pin,
  output logic uart_tx_pin,
  input wire logic cts_pin,
  output logic compare_match_flag,
  output logic cts_edge_flag,
  output logic tx_busy
);
  // ------------------------------------------------------------
  // State and ring memories
  // ------------------------------------------------------------
  aus_pkg::aus_state_t s_ff;
  aus_pkg::aus_state_t nxt_s;
  // Byte rings, indexed by the low nine address bits
  logic [7:0] tx_ring [0:(1 << aus_pkg::RING_AW) - 1];
  logic [7:0] rx_ring [0:(1 << aus_pkg::RING_AW) - 1];
  logic res_we;
  logic rx_we;
  logic [8:0] rx_waddr;
  logic [7:0] tx_rd;
  logic [7:0] rx_rd;
  logic [23:0] iw_addr;
  logic [31:0] iw_data;
  logic iw_en;
  logic tx_empty_request;
  logic rx_full_request;
  logic [7:0] upper;
  logic [23:0] rx_next;
  logic rx_store;
  logic cts_rise;

  assign tx_rd = tx_ring[s_ff.txsrc[8:0]];
  assign rx_rd = rx_ring[s_ff.rxrptr];

  // Wrap inside the ring, upper address bits stay put
  function automatic logic [23:0] ring_add(input logic [23:0] a, input logic [23:0] d);
    logic [8:0] lo;
    lo = 9'(a[8:0] + d[8:0]);
    ring_add = {a[23:9], lo};
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    res_we = 1'b0;
    rx_we = 1'b0;
    rx_waddr = s_ff.rxwptr[8:0];
    iw_addr = aus_pkg::RESULT_ADDR;
    iw_data = 32'h0000_0000;
    iw_en = 1'b0;
    upper = s_ff.result[31:24];
    tx_empty_request = !s_ff.tdr_full;
    rx_full_request = s_ff.rdr_full;
    rx_next = ring_add(s_ff.rxwptr, 24'h000001);
    rx_store = (s_ff.rx_st == aus_pkg::SER_STOP) && (s_ff.rx_tick == 4'h0) && s_ff.rx_s2;
    cts_rise = s_ff.cts_s2 && !s_ff.cts_prev;
    nxt_s.rdata = 32'h0000_0000;

    // Pin synchronisers; first stage feeds only the second
    nxt_s.rx_s1 = uart_rx_pin;
    nxt_s.rx_s2 = s_ff.rx_s1;
    nxt_s.rx_prev = s_ff.rx_s2;
    nxt_s.cts_s1 = cts_pin;
    nxt_s.cts_s2 = s_ff.cts_s1;
    nxt_s.cts_prev = s_ff.cts_s2;

    // --------------------------------------------------------
    // Register bus writes
    // --------------------------------------------------------
    if (bus.wr) begin
      case (bus.addr)
        aus_pkg::REG_CTRL: begin
          nxt_s.en = bus.wdata[aus_pkg::CTRL_EN];
          nxt_s.fmt3 = bus.wdata[aus_pkg::CTRL_FMT3];
        end
        aus_pkg::REG_STATUS: begin
          if (bus.wdata[aus_pkg::STS_CMPF]) nxt_s.cmpf = 1'b0;
          if (bus.wdata[aus_pkg::STS_CTSF]) nxt_s.ctsf = 1'b0;
          if (bus.wdata[aus_pkg::STS_RXOVR]) nxt_s.rxovr = 1'b0;
        end
        // A compare hit in the same cycle still lands
        aus_pkg::REG_ERRACC: nxt_s.err_acc = 8'h00;
        aus_pkg::REG_RESDST: nxt_s.res_dst = bus.wdata[23:0];
        aus_pkg::REG_CMPREF: nxt_s.cmp_ref = bus.wdata[7:0];
        aus_pkg::REG_RXRPTR: nxt_s.rxrptr = bus.wdata[8:0];
        default: ;
      endcase
    end

    // --------------------------------------------------------
    // Register bus reads, data one cycle later
    // --------------------------------------------------------
    // Unmapped addresses read as zero
    if (bus.rd) begin
      case (bus.addr)
        aus_pkg::REG_CTRL: nxt_s.rdata = {30'h0, s_ff.fmt3, s_ff.en};
        aus_pkg::REG_STATUS: nxt_s.rdata = {28'h0, s_ff.rxovr, s_ff.ctsf, s_ff.cmpf, tx_busy};
        aus_pkg::REG_ERRACC: nxt_s.rdata = {24'h0, s_ff.err_acc};
        aus_pkg::REG_RESDST: nxt_s.rdata = {8'h00, s_ff.res_dst};
        aus_pkg::REG_CMPREF: nxt_s.rdata = {24'h0, s_ff.cmp_ref};
        aus_pkg::REG_RXWPTR: nxt_s.rdata = {8'h00, s_ff.rxwptr};
        aus_pkg::REG_RXRPTR: nxt_s.rdata = {23'h0, s_ff.rxrptr};
        aus_pkg::REG_RXBYTE: begin
          nxt_s.rdata = {24'h0, rx_rd};
          nxt_s.rxrptr = 9'(s_ff.rxrptr + 9'h001);
        end
        aus_pkg::REG_RESULT: nxt_s.rdata = s_ff.result;
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end

    // Clear-to-send watched for rising edges, no filter; set wins
    if (cts_rise) nxt_s.ctsf = 1'b1;

    // --------------------------------------------------------
    // Chained transfer engine, one step per cycle
    // --------------------------------------------------------
    case (s_ff.ch)
      aus_pkg::CH_IDLE: begin
        // Busy chain drops further conversion events
        if (conversion_done_request && s_ff.en) nxt_s.ch = aus_pkg::CH_RES;
      end
      aus_pkg::CH_RES: begin
        nxt_s.result = conv_result;
        res_we = 1'b1;
        nxt_s.ch = aus_pkg::CH_SRC;
      end
      aus_pkg::CH_SRC: begin
        // Byte 0 leaves by the kick, so DMA starts one in
        iw_en = 1'b1;
        iw_addr = aus_pkg::TXSRC_ADDR;
        iw_data = {8'h00, ring_add(s_ff.res_dst, 24'h000001)};
        nxt_s.ch = aus_pkg::CH_CNT;
      end
      aus_pkg::CH_CNT: begin
        // Remaining bytes only, kicked byte excluded
        iw_en = 1'b1;
        iw_addr = aus_pkg::TXCNT_ADDR;
        iw_data = {16'h0000, s_ff.fmt3 ? aus_pkg::CNT_FMT3 : aus_pkg::CNT_FMT4};
        nxt_s.ch = aus_pkg::CH_KICK;
      end
      aus_pkg::CH_KICK: begin
        iw_en = 1'b1;
        iw_addr = aus_pkg::TDR_ADDR;
        iw_data = {24'h0, s_ff.result[7:0]};
        nxt_s.ch = aus_pkg::CH_DOC;
      end
      aus_pkg::CH_DOC: begin
        iw_en = s_ff.fmt3;
        iw_addr = aus_pkg::CMP_ADDR;
        iw_data = {24'h0, upper};
        // Back to idle silently, nothing signals the processor
        nxt_s.ch = aus_pkg::CH_IDLE;
      end
      default: nxt_s.ch = aus_pkg::CH_IDLE;
    endcase

    // Internal short-address write decode
    if (iw_en) begin
      case (iw_addr)
        aus_pkg::TXSRC_ADDR: nxt_s.txsrc = iw_data[23:0];
        aus_pkg::TXCNT_ADDR: nxt_s.txcnt = iw_data[15:0];
        aus_pkg::TDR_ADDR: begin
          nxt_s.uart_tx_data_reg = iw_data[7:0];
          nxt_s.tdr_full = 1'b1;
          nxt_s.dma_en = 1'b1;
        end
        aus_pkg::CMP_ADDR: begin
          // Data comparison mode, not-equal detection
          if (iw_data[7:0] != s_ff.cmp_ref) begin
            nxt_s.cmpf = 1'b1;
            nxt_s.err_acc = nxt_s.err_acc | iw_data[7:0];
          end
        end
        default: ;
      endcase
    end

    // --------------------------------------------------------
    // Transmit DMA: one byte per empty request, same cycle
    // --------------------------------------------------------
    // Stalls while a chain step owns the internal write port
    if (tx_empty_request && s_ff.dma_en && !iw_en) begin
      if (s_ff.txcnt != 16'h0000) begin
        nxt_s.uart_tx_data_reg = tx_rd;
        nxt_s.tdr_full = 1'b1;
        nxt_s.txsrc = ring_add(s_ff.txsrc, 24'h000001);
        nxt_s.txcnt = 16'(s_ff.txcnt - 16'h0001);
      end else begin
        // Transfer finished: prepare slot for the next result
        nxt_s.dma_en = 1'b0;
        nxt_s.res_dst = ring_add(s_ff.res_dst, aus_pkg::RES_STRIDE);
      end
    end

    // --------------------------------------------------------
    // UART transmitter, 8N1, LSB first, no flow control
    // --------------------------------------------------------
    case (s_ff.tx_st)
      aus_pkg::SER_IDLE: begin
        nxt_s.tx_pin = 1'b1;
        // CTS does not gate sending; software watches its flag
        if (s_ff.tdr_full) begin
          nxt_s.tx_sh = s_ff.uart_tx_data_reg;
          nxt_s.tdr_full = 1'b0;
          nxt_s.tx_pin = 1'b0;
          nxt_s.tx_tick = aus_pkg::BIT_LAST;
          nxt_s.tx_st = aus_pkg::SER_START;
        end
      end
      aus_pkg::SER_START, aus_pkg::SER_DATA: begin
        if (s_ff.tx_tick == 4'h0) begin
          nxt_s.tx_tick = aus_pkg::BIT_LAST;
          if (s_ff.tx_st == aus_pkg::SER_START) begin
            nxt_s.tx_pin = s_ff.tx_sh[0];
            nxt_s.tx_bit = 3'h0;
            nxt_s.tx_st = aus_pkg::SER_DATA;
          end else if (s_ff.tx_bit == aus_pkg::BITS_LAST) begin
            nxt_s.tx_pin = 1'b1;
            nxt_s.tx_st = aus_pkg::SER_STOP;
          end else begin
            nxt_s.tx_sh = {1'b0, s_ff.tx_sh[7:1]};
            nxt_s.tx_pin = s_ff.tx_sh[1];
            nxt_s.tx_bit = 3'(s_ff.tx_bit + 3'h1);
          end
        end else begin
          nxt_s.tx_tick = 4'(s_ff.tx_tick - 4'h1);
        end
      end
      aus_pkg::SER_STOP: begin
        // Single stop bit, no parity
        if (s_ff.tx_tick == 4'h0) nxt_s.tx_st = aus_pkg::SER_IDLE;
        else nxt_s.tx_tick = 4'(s_ff.tx_tick - 4'h1);
      end
      default: nxt_s.tx_st = aus_pkg::SER_IDLE;
    endcase

    // --------------------------------------------------------
    // UART receiver, mid-bit sampling
    // --------------------------------------------------------
    // Half-bit wait centres every sample in its bit
    case (s_ff.rx_st)
      aus_pkg::SER_IDLE: begin
        if (s_ff.rx_prev && !s_ff.rx_s2) begin
          nxt_s.rx_tick = aus_pkg::HALF_CYC;
          nxt_s.rx_st = aus_pkg::SER_START;
        end
      end
      aus_pkg::SER_START: begin
        if (s_ff.rx_tick != 4'h0) begin
          nxt_s.rx_tick = 4'(s_ff.rx_tick - 4'h1);
        end else if (s_ff.rx_s2) begin
          // Glitch shorter than half a bit
          nxt_s.rx_st = aus_pkg::SER_IDLE;
        end else begin
          nxt_s.rx_tick = aus_pkg::BIT_LAST;
          nxt_s.rx_bit = 3'h0;
          nxt_s.rx_st = aus_pkg::SER_DATA;
        end
      end
      aus_pkg::SER_DATA: begin
        if (s_ff.rx_tick != 4'h0) begin
          nxt_s.rx_tick = 4'(s_ff.rx_tick - 4'h1);
        end else begin
          nxt_s.rx_sh = {s_ff.rx_s2, s_ff.rx_sh[7:1]};
          nxt_s.rx_tick = aus_pkg::BIT_LAST;
          nxt_s.rx_bit = 3'(s_ff.rx_bit + 3'h1);
          if (s_ff.rx_bit == aus_pkg::BITS_LAST) nxt_s.rx_st = aus_pkg::SER_STOP;
        end
      end
      aus_pkg::SER_STOP: begin
        if (s_ff.rx_tick != 4'h0) begin
          nxt_s.rx_tick = 4'(s_ff.rx_tick - 4'h1);
        end else begin
          // Framing error drops the byte
          if (s_ff.rx_s2) begin
            nxt_s.uart_rx_data_reg = s_ff.rx_sh;
            nxt_s.rdr_full = 1'b1;
          end
          nxt_s.rx_st = aus_pkg::SER_IDLE;
        end
      end
      default: nxt_s.rx_st = aus_pkg::SER_IDLE;
    endcase

    // Receive DMA, free running into the ring; overrun is flagged
    if (rx_full_request) begin
      rx_we = 1'b1;
      nxt_s.rxwptr = rx_next;
      if (rx_next == {s_ff.rxwptr[23:9], s_ff.rxrptr}) nxt_s.rxovr = 1'b1;
      // A byte stored in this same cycle keeps the buffer full
      if (!rx_store) nxt_s.rdr_full = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Clear all, then the reset constants and the non-zero idle levels
      s_ff <= '0;
      s_ff.cmp_ref <= aus_pkg::CMP_REF_RST;
      s_ff.res_dst <= aus_pkg::RING_BASE_RST;
      s_ff.rxwptr <= aus_pkg::RING_BASE_RST;
      s_ff.ch <= aus_pkg::CH_IDLE;
      s_ff.tx_st <= aus_pkg::SER_IDLE;
      s_ff.rx_st <= aus_pkg::SER_IDLE;
      s_ff.tx_pin <= 1'b1;
      s_ff.rx_s1 <= 1'b1;
      s_ff.rx_s2 <= 1'b1;
      s_ff.rx_prev <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Ring memories carry no reset; contents are don't-care until written
  always_ff @(posedge ref_clk) begin
    if (res_we) begin
      for (int i = 0; i < 4; i++) begin
        tx_ring[9'(s_ff.res_dst[8:0] + 9'(i))] <= conv_result[8*i +: 8];
      end
    end
    if (rx_we) rx_ring[rx_waddr] <= s_ff.uart_rx_data_reg;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata = s_ff.rdata;
  assign uart_tx_pin = s_ff.tx_pin;
  assign compare_match_flag = s_ff.cmpf;
  assign cts_edge_flag = s_ff.ctsf;
  // Busy spans event to last stop bit; software polls it
  assign tx_busy = (s_ff.tx_st != aus_pkg::SER_IDLE) || s_ff.tdr_full || s_ff.dma_en ||
                   (s_ff.ch != aus_pkg::CH_IDLE);
endmodule // aus_streamer
`default_nettype wire

/* aus_pkg.sv */
// Constants, register map and types for the result streamer.
// Assumes one 40 MHz clock shared by converter, bus and UART.
`default_nettype none
package aus_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD_BPS = 4000000;
  localparam logic [3:0] BIT_CYC = 4'(CLK_HZ / BAUD_BPS);
  localparam logic [3:0] BIT_LAST = 4'(BIT_CYC - 4'h1);
  localparam logic [3:0] HALF_CYC = 4'(BIT_CYC / 4'h2);
  localparam logic [2:0] BITS_LAST = 3'h7;
  // ------------------------------------------------------------
  // Internal 24-bit short addresses
  // ------------------------------------------------------------
  localparam logic [23:0] RESULT_ADDR = 24'h0A1070;
  localparam logic [23:0] TXSRC_ADDR = 24'h082000;
  localparam logic [23:0] TXCNT_ADDR = 24'h082008;
  localparam logic [23:0] TDR_ADDR = 24'h08A023;
  localparam logic [23:0] CMP_ADDR = 24'h08B082;
  localparam int unsigned RING_AW = 9;
  localparam logic [23:0] RING_BASE_RST = 24'h000000;
  localparam logic [23:0] RES_STRIDE = 24'h000004;
  localparam logic [15:0] CNT_FMT3 = 16'h0002;
  localparam logic [15:0] CNT_FMT4 = 16'h0003;
  localparam logic [7:0] CMP_REF_RST = 8'h00;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERRACC = 8'h08;
  localparam logic [7:0] REG_RESDST = 8'h0C;
  localparam logic [7:0] REG_CMPREF = 8'h10;
  localparam logic [7:0] REG_RXWPTR = 8'h14;
  localparam logic [7:0] REG_RXRPTR = 8'h18;
  localparam logic [7:0] REG_RXBYTE = 8'h1C;
  localparam logic [7:0] REG_RESULT = 8'h20;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_FMT3 = 1;
  localparam int unsigned STS_TXBUSY = 0;
  localparam int unsigned STS_CMPF = 1;
  localparam int unsigned STS_CTSF = 2;
  localparam int unsigned STS_RXOVR = 3;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } aus_bus_t;
  typedef enum logic [5:0] {
    CH_IDLE = 6'h01, CH_RES = 6'h02, CH_SRC = 6'h04,
    CH_CNT = 6'h08, CH_KICK = 6'h10, CH_DOC = 6'h20
  } aus_chain_t;
  typedef enum logic [3:0] {
    SER_IDLE = 4'h1, SER_START = 4'h2, SER_DATA = 4'h4, SER_STOP = 4'h8
  } aus_ser_t;
  typedef struct packed {
    logic en;
    logic fmt3;
    logic [7:0] cmp_ref;
    logic [7:0] err_acc;
    logic cmpf;
    logic ctsf;
    logic rxovr;
    logic [23:0] res_dst;
    logic [31:0] result;
    aus_chain_t ch;
    logic [23:0] txsrc;
    logic [15:0] txcnt;
    logic dma_en;
    logic [7:0] uart_tx_data_reg;
    logic tdr_full;
    aus_ser_t tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic [3:0] tx_tick;
    logic tx_pin;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    aus_ser_t rx_st;
    logic [7:0] rx_sh;
    logic [2:0] rx_bit;
    logic [3:0] rx_tick;
    logic [7:0] uart_rx_data_reg;
    logic rdr_full;
    logic [23:0] rxwptr;
    logic [8:0] rxrptr;
    logic cts_s1;
    logic cts_s2;
    logic cts_prev;
    logic [31:0] rdata;
  } aus_state_t;
endpackage
`default_nettype wire

/* aus_checker.sv */
// Port-level assertions for the result streamer.
// Assumes the aus_streamer port list; bound below its endmodule.
`default_nettype none
module aus_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire aus_pkg::aus_bus_t bus,
  input wire logic [31:0] reg_rdata,
  input wire logic conversion_done_request,
  input wire logic uart_tx_pin,
  input wire logic cts_pin,
  input wire logic compare_match_flag,
  input wire logic cts_edge_flag,
  input wire logic tx_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Shadow of enable and flag clears
  // ----------------------------------------
  logic en_ff;
  logic rd_ff;
  logic clr_cmp_ff;
  logic clr_cts_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'b0;
      rd_ff <= 1'b0;
      clr_cmp_ff <= 1'b0;
      clr_cts_ff <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == aus_pkg::REG_CTRL) begin
        en_ff <= bus.wdata[0];
      end
      rd_ff <= bus.rd;
      clr_cmp_ff <= bus.wr && bus.addr == aus_pkg::REG_STATUS && bus.wdata[1];
      clr_cts_ff <= bus.wr && bus.addr == aus_pkg::REG_STATUS && bus.wdata[2];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_accept;
    conversion_done_request && en_ff && !tx_busy;
  endsequence
  sequence s_low_bit;
    (!uart_tx_pin) [*8];
  endsequence
  a_kick_start: assert property (s_accept |-> ##[4:8] $fell(uart_tx_pin)) else $error("no start bit");
  a_busy_follows: assert property (s_accept |=> tx_busy) else $error("event not taken");
  a_low_width: assert property ($fell(uart_tx_pin) |-> s_low_bit) else $error("short low bit");
  a_high_width: assert property ($rose(uart_tx_pin) |-> uart_tx_pin [*8]) else $error("short high bit");
  a_idle_high: assert property (!tx_busy |-> uart_tx_pin) else $error("tx not idle high");
  a_rdata_quiet: assert property (!rd_ff |-> reg_rdata == 32'h0) else $error("stray read data");
  a_cts_seen: assert property ($rose(cts_pin) |-> ##[1:4] cts_edge_flag) else $error("cts edge missed");
  a_cts_sticky: assert property ($fell(cts_edge_flag) |-> clr_cts_ff) else $error("cts flag lost");
  a_cmp_sticky: assert property ($fell(compare_match_flag) |-> clr_cmp_ff) else $error("cmp flag lost");
  a_cmp_in_chain: assert property ($rose(compare_match_flag) |-> $past(tx_busy)) else $error("cmp outside chain");
endmodule // aus_checker
bind aus_streamer aus_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .reg_rdata(reg_rdata),
  .conversion_done_request(conversion_done_request), .uart_tx_pin(uart_tx_pin), .cts_pin(cts_pin),
  .compare_match_flag(compare_match_flag), .cts_edge_flag(cts_edge_flag), .tx_busy(tx_busy));
`default_nettype wire

/* aus_host_model.sv */
// Host side of the UART link: 8N1 at ten clocks per bit.
// Assumes the bench clock; the clear-to-send line is driven by the bench.
`default_nettype none
module aus_host_model (
  input wire logic ref_clk,
  input wire logic tx_line,
  output logic rx_line,
  output logic cts_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial begin
    rx_line = 1'b1;
    cts_line = 1'b0;
  end
  // ----------------------------------------
  // Receiver: mid-bit sampling, LSB first
  // ----------------------------------------
  always begin
    @(negedge tx_line);
    repeat (5) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (10) @(posedge ref_clk);
      sh = {tx_line, sh[7:1]};
    end
    repeat (10) @(posedge ref_clk);
    if (tx_line === 1'b1) begin
      got_q.push_back(sh);
    end
  end
  // Clear-to-send level raised by the host when it is ready
  task automatic set_cts(input logic lvl);
    cts_line <= lvl;
  endtask
  // Transmit ignores clear-to-send: no flow control on this link
  task automatic send_byte(input logic [7:0] b, input logic stop_ok);
    @(posedge ref_clk);
    rx_line <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (10) @(posedge ref_clk);
      rx_line <= b[i];
    end
    repeat (10) @(posedge ref_clk);
    rx_line <= stop_ok;
    repeat (10) @(posedge ref_clk);
    rx_line <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask
endmodule // aus_host_model
`default_nettype wire

/* aus_streamer_tb.sv */
// Self-checking bench for the result streamer.
// Assumes aus_host_model at the UART and the bound checker.
`default_nettype none
module aus_streamer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  aus_pkg::aus_bus_t bus = '0;
  logic [31:0] reg_rdata;
  logic conversion_done_request = 1'b0;
  logic [31:0] conv_result = 32'h0;
  logic uart_rx_pin;
  logic uart_tx_pin;
  logic cts_pin;
  logic compare_match_flag;
  logic cts_edge_flag;
  logic tx_busy;
  int fails = 0;
  int samples_checked = 0;
  int seed = 41371;
  int cyc = 0;
  logic [31:0] v;
  logic [31:0] d;
  logic [7:0] acc;
  logic [7:0] rxb[3];
  always #12.5 ref_clk = ~ref_clk;
  aus_streamer DUT (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .reg_rdata(reg_rdata),
    .conversion_done_request(conversion_done_request), .conv_result(conv_result), .uart_rx_pin(uart_rx_pin),
    .uart_tx_pin(uart_tx_pin), .cts_pin(cts_pin), .compare_match_flag(compare_match_flag),
    .cts_edge_flag(cts_edge_flag), .tx_busy(tx_busy));
  aus_host_model hm (.ref_clk(ref_clk), .tx_line(uart_tx_pin), .rx_line(uart_rx_pin), .cts_line(cts_pin));
  // ----------------------------------------
  // Checking and bus helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [23:0] next_slot(input logic [23:0] a);
    return {a[23:9], a[8:0] + 9'h004};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 dat = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    rd(a, t);
    chk_reg(t, exp);
  endtask
  task automatic fire(input logic [31:0] val);
    @(posedge ref_clk);
    conversion_done_request <= 1'b1;
    conv_result <= val;
    @(posedge ref_clk);
    conversion_done_request <= 1'b0;
  endtask
  task automatic settle(input int n);
    for (int k = 0; k < 3000 && hm.got_q.size() < n; k++) @(posedge ref_clk);
    for (int k = 0; k < 300 && tx_busy !== 1'b0; k++) @(posedge ref_clk);
    repeat (30) @(posedge ref_clk);
  endtask
  // One result through chain, DMA and UART; 3 or 4 bytes LSB first
  task automatic stream(input logic [31:0] val, input int n);
    logic [31:0] slot;
    rd(aus_pkg::REG_RESDST, slot);
    hm.got_q.delete();
    fire(val);
    settle(n);
    chk_reg(32'(hm.got_q.size()), 32'(n));
    for (int i = 0; i < n; i++) chk_byte(hm.got_q[i], val[8 * i +: 8]);
    rdc(aus_pkg::REG_RESULT, val);
    rdc(aus_pkg::REG_RESDST, {8'h00, next_slot(slot[23:0])});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(aus_pkg::REG_CTRL, 32'h0);
    rdc(aus_pkg::REG_STATUS, 32'h0);
    rdc(aus_pkg::REG_CMPREF, 32'h0);
    rdc(aus_pkg::REG_RXWPTR, 32'h0);
    rdc(8'h30, 32'h0);
    $display("reset test done");
    // Slot at ring top so the first advance wraps
    wr(aus_pkg::REG_RESDST, 32'h0001FC);
    wr(aus_pkg::REG_CTRL, 32'h3);
    acc = 8'h00;
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      if (i < 2) v[31:24] = 8'h00;
      stream(v, 3);
      acc |= v[31:24];
      chk_reg({31'h0, compare_match_flag}, {31'h0, acc != 8'h00});
      rdc(aus_pkg::REG_ERRACC, {24'h0, acc});
    end
    wr(aus_pkg::REG_STATUS, 32'h2);
    wr(aus_pkg::REG_ERRACC, 32'h0);
    rdc(aus_pkg::REG_STATUS, 32'h0);
    wr(aus_pkg::REG_CMPREF, 32'h5A);
    rdc(aus_pkg::REG_CMPREF, 32'h5A);
    v = $random(seed);
    v[31:24] = 8'h5A;
    stream(v, 3);
    chk_reg({31'h0, compare_match_flag}, 32'h0);
    rdc(aus_pkg::REG_ERRACC, 32'h0);
    $display("three byte test done");
    wr(aus_pkg::REG_CTRL, 32'h1);
    v = $random(seed) | 32'h80000000;
    stream(v, 4);
    chk_reg({31'h0, compare_match_flag}, 32'h0);
    hm.got_q.delete();
    // Second event lands while the chain is still stepping
    fire(v);
    fire(~v);
    settle(4);
    repeat (400) @(posedge ref_clk);
    chk_reg(32'(hm.got_q.size()), 32'h4);
    rdc(aus_pkg::REG_RESULT, v);
    wr(aus_pkg::REG_CTRL, 32'h0);
    hm.got_q.delete();
    fire(v);
    repeat (200) @(posedge ref_clk);
    chk_reg({31'h0, tx_busy}, 32'h0);
    chk_reg(32'(hm.got_q.size()), 32'h0);
    $display("four byte and drop test done");
    for (int i = 0; i < 3; i++) begin
      rxb[i] = 8'($random(seed));
      hm.send_byte(rxb[i], 1'b1);
    end
    hm.send_byte(8'hA5, 1'b0);
    repeat (20) @(posedge ref_clk);
    rdc(aus_pkg::REG_RXWPTR, 32'h3);
    for (int i = 0; i < 3; i++) rdc(aus_pkg::REG_RXBYTE, {24'h0, rxb[i]});
    rdc(aus_pkg::REG_RXRPTR, 32'h3);
    wr(aus_pkg::REG_RXRPTR, 32'h1);
    rdc(aus_pkg::REG_RXBYTE, {24'h0, rxb[1]});
    $display("receive test done");
    @(posedge ref_clk);
    hm.set_cts(1'b1);
    repeat (6) @(posedge ref_clk);
    rdc(aus_pkg::REG_STATUS, 32'h4);
    chk_reg({31'h0, cts_edge_flag}, 32'h1);
    wr(aus_pkg::REG_STATUS, 32'h4);
    rdc(aus_pkg::REG_STATUS, 32'h0);
    $display("cts test done");
    finish_test();
  end
endmodule // aus_streamer_tb
`default_nettype wire
